// ==== rtl/sync_serial_port_regs.vh ====
// Register map, field positions and timing constants of the serial port block
// Notes on behaviour
// - I2C master: buffer write while busy flags collision
// - SPI slave: buffer write mid-shift flags collision
// - SPI slave: byte completes with unread buffer flags overflow
// - SPI master never raises overflow
// - I2C slave receive with unread buffer flags overflow
// - Enable hands pins to the port
// - SPI clock idle level follows polarity bit
// - I2C slave: polarity bit zero stretches SCL
// - Codes 0-3: SPI master, fixed or timer rates
// - Codes 4-5: SPI slave, select gating or not
// - Codes 6-7: I2C slave, 7 or 10 bit
// - Code 8: I2C master, rate from baud register
// - Codes E,F: I2C slave with start/stop events; code B idle
// - All-zero write address is general call
// - General call needs its enable bit
// - After start, compare eight bits with both addresses
// - Match loads buffer at bit 8, flag at ninth fall
// - 10-bit match sets update flag for second half
// - General call in 10-bit skips second half
`ifndef SYNC_SERIAL_PORT_REGS_VH
`define SYNC_SERIAL_PORT_REGS_VH
// Byte addresses on the register bus
`define SPC_A_BUF 8'h00
`define SPC_A_STAT 8'h04
`define SPC_A_ABR 8'h08
`define SPC_A_CTL2 8'h0C
`define SPC_A_CTL 8'h14
// Control register fields and reset value
`define SPC_CTL_RST 8'h00
`define SPC_B_WRITE_COLLISION_FLAG 7
`define SPC_B_OV 6
`define SPC_B_EN 5
`define SPC_B_CKP 4
// Status and second control fields
`define SPC_B_BF 0
`define SPC_B_UA 1
`define SPC_B_SIF 2
`define SPC_B_GENERAL_CALL_ENABLE 7
// Mode codes
`define SPC_M_SPI_D4 4'h0
`define SPC_M_SPI_D16 4'h1
`define SPC_M_SPI_D64 4'h2
`define SPC_M_SPI_TMR 4'h3
`define SPC_M_SPI_SS 4'h4
`define SPC_M_SPI_NSS 4'h5
`define SPC_M_I2C_S7 4'h6
`define SPC_M_I2C_S10 4'h7
`define SPC_M_I2C_MST 4'h8
`define SPC_M_FW_IDLE 4'hB
`define SPC_M_FW_7 4'hE
`define SPC_M_FW_10 4'hF
// Half periods of the master serial clock in core cycles
`define SPC_HALF_D4 10'h002
`define SPC_HALF_D16 10'h008
`define SPC_HALF_D64 10'h020
`define SPC_HALF_ONE 10'h001
// Bit counts and fixed addresses
`define SPC_BITS_LAST 4'h7
`define SPC_BITS_ACK 4'h8
`define SPC_BITS_NINE 4'h9
`define SPC_GC_ADDR 8'h00
`endif

// ==== rtl/sync_serial_port.v ====
// Synchronous serial port: SPI master/slave, I2C slave and master, AHB-Lite registers
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
module sync_serial_port (
  input wire core_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire timer_two_tick,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  input wire ss_n,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  output reg port_pins_owned
);
`include "sync_serial_port_regs.vh"

  // One-hot states of the I2C slave receiver
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_ADDR2 = 5'b00100;
  localparam [4:0] ST_DATA = 5'b01000;
  localparam [4:0] ST_IGN = 5'b10000;

  // Half period of the generated serial clock for the current mode
  function [9:0] half_len;
    input [3:0] mode;
    input [7:0] abr;
    begin
      case (mode)
        `SPC_M_SPI_D4: half_len = `SPC_HALF_D4;
        `SPC_M_SPI_D16: half_len = `SPC_HALF_D16;
        `SPC_M_SPI_D64: half_len = `SPC_HALF_D64;
        default: half_len = {1'b0, abr, 1'b0} + {`SPC_HALF_D4};
      endcase
    end
  endfunction

  reg [7:0] ctrl_r;
  reg [7:0] buf_r;
  reg [7:0] abr_r;
  reg general_call_enable_r;
  reg bf_r;
  reg sif_r;
  reg ua_r;
  reg [7:0] sr_r;
  reg [3:0] bitcnt_r;
  reg busy_r;
  reg phase_r;
  reg [9:0] div_r;
  reg sdo_r;
  reg ack_r;
  reg ack_drive_r;
  reg [4:0] st_r;
  reg ph_act_r;
  reg [7:0] ph_addr_r;
  reg [4:0] pin_m_r;
  reg [4:0] pin_s_r;
  reg [4:0] pin_d_r;
  reg [31:0] rd_val;

  wire [3:0] mode = ctrl_r[3:0];
  wire en = ctrl_r[`SPC_B_EN];
  wire clock_polarity_release = ctrl_r[`SPC_B_CKP];
  // Mode decode; reserved codes fall in no group and leave the port idle
  wire m_spi_mst = en & (mode[3:2] == 2'b00);
  wire m_spi_slv = en & ((mode == `SPC_M_SPI_SS) | (mode == `SPC_M_SPI_NSS));
  wire m_i2c_mst = en & (mode == `SPC_M_I2C_MST);
  wire fw_evt = (mode == `SPC_M_FW_7) | (mode == `SPC_M_FW_10);
  wire m_i2c_slv = en & ((mode == `SPC_M_I2C_S7) | (mode == `SPC_M_I2C_S10) | fw_evt);
  wire ten_bit = (mode == `SPC_M_I2C_S10) | (mode == `SPC_M_FW_10);
  wire m_mst = m_spi_mst | m_i2c_mst;

  // Synchronised pin levels: sck, sdi, ss_n, scl, sda
  wire sck_s = pin_s_r[0];
  wire sdi_s = pin_s_r[1];
  wire ss_s = pin_s_r[2];
  wire scl_s = pin_s_r[3];
  wire sda_s = pin_s_r[4];
  wire sck_d = pin_d_r[0];
  wire scl_d = pin_d_r[3];
  wire sda_d = pin_d_r[4];

  // Slave select only gates the slave in the gated code
  wire spi_sel = ~(mode == `SPC_M_SPI_SS) | ~ss_s;
  wire sck_lead = (sck_s != sck_d) & (sck_d == clock_polarity_release);
  wire sck_trail = (sck_s != sck_d) & (sck_s == clock_polarity_release);
  wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
  wire i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire [7:0] s8 = {sr_r[6:0], sda_s};

  // Address recognition on the eighth bit after start
  wire gc_hit = general_call_enable_r & (s8 == `SPC_GC_ADDR);
  wire own_hit = (s8[7:1] == abr_r[7:1]) & ~s8[0];
  wire own2_hit = (s8 == abr_r);

  // Master clock tick; timer mode takes one timer pulse per half period
  wire [9:0] half = half_len(mode, abr_r);
  wire mst_tick = (mode == `SPC_M_SPI_TMR) ? timer_two_tick : (div_r + `SPC_HALF_ONE == half);
  // Master input bit joined to the shifter, taken late in each bit
  wire mst_in = m_i2c_mst ? sda_s : sdi_s;
  wire [7:0] mst_sh = {sr_r[6:0], mst_in};

  wire bus_take = hsel & hready & htrans[1];
  wire wr_now = ph_act_r;
  wire [31:0] wd = hwdata;
  wire buf_wr = wr_now & (ph_addr_r == `SPC_A_BUF);

  // Read value, captured in the address phase so hrdata is a flop
  always @* begin
    case (haddr[7:0])
      `SPC_A_BUF: rd_val = {24'h000000, buf_r};
      `SPC_A_STAT: rd_val = {28'h0000000, busy_r, sif_r, ua_r, bf_r};
      `SPC_A_ABR: rd_val = {24'h000000, abr_r};
      `SPC_A_CTL2: rd_val = {24'h000000, general_call_enable_r, 7'h00};
      `SPC_A_CTL: rd_val = {24'h000000, ctrl_r};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Two-flop synchronisers for every pin input, plus an edge history stage
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_r <= 5'h1F;
      pin_s_r <= 5'h1F;
      pin_d_r <= 5'h1F;
    end else begin
      pin_m_r <= {sda_i, scl_i, ss_n, sdi, sck_i};
      pin_s_r <= pin_m_r;
      pin_d_r <= pin_s_r;
    end
  end

  // Registers and shift engines; hardware sets come last so they win over clears
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ph_act_r <= 1'b0;
      ph_addr_r <= 8'h00;
      ctrl_r <= `SPC_CTL_RST;
      buf_r <= 8'h00;
      abr_r <= 8'h00;
      general_call_enable_r <= 1'b0;
      bf_r <= 1'b0;
      sif_r <= 1'b0;
      ua_r <= 1'b0;
      sr_r <= 8'h00;
      bitcnt_r <= 4'h0;
      busy_r <= 1'b0;
      phase_r <= 1'b0;
      div_r <= 10'h000;
      sdo_r <= 1'b0;
      ack_r <= 1'b0;
      ack_drive_r <= 1'b0;
      st_r <= ST_IDLE;
    end else begin
      // Bus address phase: zero wait states, buffer read frees the buffer
      ph_act_r <= bus_take & hwrite;
      if (bus_take) begin
        ph_addr_r <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_val;
          if (haddr[7:0] == `SPC_A_BUF)
            bf_r <= 1'b0;
        end
      end
      // Bus data phase writes; flags take software value, hardware may override below
      if (wr_now) begin
        case (ph_addr_r)
          `SPC_A_CTL: ctrl_r <= wd[7:0];
          `SPC_A_ABR: abr_r <= wd[7:0];
          `SPC_A_CTL2: general_call_enable_r <= wd[`SPC_B_GENERAL_CALL_ENABLE];
          `SPC_A_STAT: begin
            sif_r <= wd[`SPC_B_SIF];
            ua_r <= wd[`SPC_B_UA];
          end
          default: ;
        endcase
      end
      // Buffer write: refused with collision when a master is busy or the SPI slave is mid-byte
      if (buf_wr) begin
        if (m_mst & busy_r)
          ctrl_r[`SPC_B_WRITE_COLLISION_FLAG] <= 1'b1;
        else if (m_spi_slv & (bitcnt_r != 4'h0))
          ctrl_r[`SPC_B_WRITE_COLLISION_FLAG] <= 1'b1;
        else begin
          buf_r <= wd[7:0];
          sr_r <= wd[7:0];
          sdo_r <= wd[7];
          if (m_mst) begin
            busy_r <= 1'b1;
            bitcnt_r <= 4'h0;
            phase_r <= 1'b0;
            div_r <= 10'h000;
          end
        end
      end
      if (!en) begin
        // Disabled: engines parked so a re-enable starts clean
        busy_r <= 1'b0;
        bitcnt_r <= 4'h0;
        st_r <= ST_IDLE;
        ack_r <= 1'b0;
        ack_drive_r <= 1'b0;
      end else if (m_mst & busy_r) begin
        // Master: trailing edge samples and shifts; pin lag makes an early sample stale
        div_r <= mst_tick ? 10'h000 : div_r + `SPC_HALF_ONE;
        if (mst_tick) begin
          if (!phase_r) begin
            phase_r <= 1'b1;
          end else begin
            phase_r <= 1'b0;
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r <= `SPC_BITS_LAST)
              sr_r <= mst_sh;
            // I2C releases the data line for the acknowledge clock
            sdo_r <= mst_sh[7] | (m_i2c_mst & (bitcnt_r == `SPC_BITS_LAST));
            if (bitcnt_r == (m_i2c_mst ? `SPC_BITS_ACK : `SPC_BITS_LAST)) begin
              busy_r <= 1'b0;
              bitcnt_r <= 4'h0;
              buf_r <= (bitcnt_r <= `SPC_BITS_LAST) ? mst_sh : sr_r;
              bf_r <= 1'b1;
              sif_r <= 1'b1;
            end
          end
        end
      end else if (m_spi_slv) begin
        if (!spi_sel)
          bitcnt_r <= 4'h0;
        else if (sck_lead)
          sr_r <= {sr_r[6:0], sdi_s};
        else if (sck_trail) begin
          sdo_r <= sr_r[7];
          bitcnt_r <= bitcnt_r + 4'h1;
          if (bitcnt_r == `SPC_BITS_LAST) begin
            bitcnt_r <= 4'h0;
            sif_r <= 1'b1;
            // Unread buffer: new byte dropped, overflow raised
            if (bf_r)
              ctrl_r[`SPC_B_OV] <= 1'b1;
            else begin
              buf_r <= sr_r;
              bf_r <= 1'b1;
            end
          end
        end
      end else if (m_i2c_slv) begin
        if (i2c_start) begin
          st_r <= ST_ADDR;
          bitcnt_r <= 4'h0;
          ack_r <= 1'b0;
          ack_drive_r <= 1'b0;
          if (fw_evt)
            sif_r <= 1'b1;
        end else if (i2c_stop) begin
          st_r <= ST_IDLE;
          ack_drive_r <= 1'b0;
          if (fw_evt)
            sif_r <= 1'b1;
        end else if (scl_rise & (st_r != ST_IDLE) & (st_r != ST_IGN)) begin
          if (bitcnt_r == `SPC_BITS_ACK)
            bitcnt_r <= `SPC_BITS_NINE;
          else if (bitcnt_r < `SPC_BITS_ACK) begin
            sr_r <= s8;
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          if (bitcnt_r == `SPC_BITS_LAST) begin
            case (st_r)
              ST_ADDR: begin
                if (gc_hit | own_hit) begin
                  if (bf_r) begin
                    ctrl_r[`SPC_B_OV] <= 1'b1;
                    st_r <= ST_IGN;
                  end else begin
                    buf_r <= s8;
                    bf_r <= 1'b1;
                    ack_r <= 1'b1;
                    // General call skips the second half in 10-bit mode
                    st_r <= (ten_bit & ~gc_hit) ? ST_ADDR2 : ST_DATA;
                    ua_r <= ten_bit & ~gc_hit;
                  end
                end else
                  st_r <= ST_IGN;
              end
              ST_ADDR2: begin
                if (own2_hit & ~bf_r) begin
                  buf_r <= s8;
                  bf_r <= 1'b1;
                  ack_r <= 1'b1;
                  st_r <= ST_DATA;
                end else begin
                  if (own2_hit)
                    ctrl_r[`SPC_B_OV] <= 1'b1;
                  st_r <= ST_IGN;
                end
              end
              ST_DATA: begin
                if (bf_r)
                  ctrl_r[`SPC_B_OV] <= 1'b1;
                else begin
                  buf_r <= s8;
                  bf_r <= 1'b1;
                  ack_r <= 1'b1;
                end
              end
              default: st_r <= ST_IGN;
            endcase
          end
        end else if (scl_fall) begin
          if (bitcnt_r == `SPC_BITS_ACK)
            ack_drive_r <= ack_r;
          else if (bitcnt_r == `SPC_BITS_NINE) begin
            // End of the acknowledge clock
            ack_drive_r <= 1'b0;
            bitcnt_r <= 4'h0;
            ack_r <= 1'b0;
            if (ack_r)
              sif_r <= 1'b1;
          end
        end
      end
    end
  end

  // Pin drivers; all released unless the port owns the pins
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pins_owned <= 1'b0;
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      port_pins_owned <= en;
      sck_o <= clock_polarity_release ^ (busy_r & phase_r);
      sck_oe <= m_spi_mst;
      sdo <= sdo_r;
      sdo_oe <= m_spi_mst | (m_spi_slv & spi_sel);
      scl_o <= 1'b0;
      // Open drain: low while master clock is low or slave stretches
      scl_oe <= (m_i2c_mst & busy_r & ~phase_r) | (m_i2c_slv & ~clock_polarity_release);
      sda_o <= 1'b0;
      sda_oe <= (m_i2c_mst & busy_r & ~sdo_r) | (m_i2c_slv & ack_drive_r);
    end
  end

endmodule

// ==== tb/sync_serial_port_props.sv ====
// Checker of control, pin and bus timing of the serial port
`timescale 1ns/100ps
`include "sync_serial_port_regs.vh"
module sync_serial_port_props (
  input wire core_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire sck_o,
  input wire sck_oe,
  input wire sdo_oe,
  input wire ss_n,
  input wire scl_i,
  input wire scl_oe,
  input wire sda_oe,
  input wire port_pins_owned
);
  reg wa_r;
  reg [7:0] ad_r;
  reg [7:0] ctl_r;
  wire [3:0] md = ctl_r[3:0];
  wire en = ctl_r[5];
  wire slv = en && (md == 4'h6 || md == 4'h7 || md >= 4'hE);
  // Shadow of the control byte, taken from bus write data phases
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wa_r <= 1'h0;
      ad_r <= 8'h00;
      ctl_r <= 8'h00;
    end else begin
      wa_r <= hsel && hready && htrans[1] && hwrite;
      ad_r <= haddr[7:0];
      if (wa_r && ad_r == `SPC_A_CTL) ctl_r <= hwdata[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ctl_write;
    wa_r && ad_r == `SPC_A_CTL;
  endsequence
  sequence ss_high;
    en && md == 4'h4 && ss_n [*5];
  endsequence
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_PINS: assert property (ctl_write |-> ##2 port_pins_owned == $past(hwdata[5], 2))
    else $error("pin ownership does not follow enable");
  AST_PINS_OFF: assert property (!port_pins_owned [*2] |-> !(sck_oe || sdo_oe || scl_oe || sda_oe))
    else $error("pin driven while port disabled");
  AST_IDLE_CLK: assert property ($rose(sck_oe) |-> sck_o == ctl_r[4])
    else $error("serial clock idle level wrong");
  AST_MASTER_CLK: assert property ($stable(ctl_r) [*3] |-> sck_oe == (en && md < 4'h4))
    else $error("serial clock drive does not match mode");
  AST_SS_GATE: assert property (ss_high |-> !sdo_oe)
    else $error("data out driven while deselected");
  AST_NO_SS: assert property (en && md == 4'h5 [*3] |-> sdo_oe)
    else $error("data out not driven without select");
  AST_STRETCH: assert property (slv && !ctl_r[4] [*3] |-> scl_oe)
    else $error("clock not held low for stretch");
  AST_FW_IDLE: assert property (en && md == 4'hB [*3] |-> !(scl_oe || sda_oe || sck_oe))
    else $error("pins driven in firmware idle mode");
  AST_ACK_LOW: assert property (slv && $changed(sda_oe) |-> !scl_i)
    else $error("acknowledge changed while clock high");
endmodule
bind sync_serial_port sync_serial_port_props chk (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sck_o(sck_o), .sck_oe(sck_oe),
  .sdo_oe(sdo_oe), .ss_n(ss_n), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .port_pins_owned(port_pins_owned));

// ==== tb/serial_far_end.sv ====
// Far-side bus model: I2C master, SPI master and SPI slave
`timescale 1ns/100ps
module serial_far_end (
  input wire core_clk,
  input wire scl_oe,
  input wire sda_oe,
  input wire sck_o,
  input wire sck_oe,
  input wire sdo,
  input wire cpol,
  output wire scl_i,
  output wire sda_i,
  output reg sck_i,
  output wire sdi
);
  reg scl_r = 1'h1;
  reg sda_r = 1'h1;
  reg sdi_r = 1'h0;
  reg [7:0] stx_r = 8'h00;
  reg [7:0] srx_r = 8'h00;
  // Pulled-up open-drain lines; slave bit shifts out while the port is master
  assign scl_i = scl_r && !scl_oe;
  assign sda_i = sda_r && !sda_oe;
  assign sdi = sck_oe ? stx_r[7] : sdi_r;
  initial sck_i = 1'h0;
  // Slave answer: sample on leading edge, rotate on trailing so the byte repeats
  always @(sck_o) begin
    if (sck_oe && sck_o != cpol) srx_r <= {srx_r[6:0], sdo};
    if (sck_oe && sck_o == cpol) stx_r <= {stx_r[6:0], stx_r[7]};
  end
  task hw(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task i2c_start;
    sda_r <= 1'h0;
    hw(8);
    scl_r <= 1'h0;
    hw(8);
  endtask
  task i2c_stop;
    sda_r <= 1'h0;
    hw(8);
    scl_r <= 1'h1;
    hw(8);
    sda_r <= 1'h1;
    hw(8);
  endtask
  // Eight bits then the acknowledge clock; a stretched clock is waited out
  task i2c_byte(input [7:0] b, output reg ack);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      sda_r <= (i == 0) ? 1'h1 : b[i-1];
      hw(8);
      scl_r <= 1'h1;
      hw(1);
      while (!scl_i) hw(1);
      hw(4);
      if (i == 0) ack = !sda_i;
      hw(4);
      scl_r <= 1'h0;
    end
    hw(8);
  endtask
  // Clock one byte into a slave port; its reply is read at each leading edge
  task spi_byte(input [7:0] b, output reg [7:0] r);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sdi_r <= b[i];
      hw(8);
      sck_i <= !cpol;
      r[i] = sdo;
      hw(8);
      sck_i <= cpol;
    end
    sdi_r <= !b[0];
    hw(8);
  endtask
endmodule

// ==== tb/sync_serial_port_tb.sv ====
// Self-checking bench of the serial port against expected register and wire values
`timescale 1ns/100ps
`include "sync_serial_port_regs.vh"
module sync_serial_port_tb;
  reg core_clk = 1'h0;
  reg rst_n = 1'h0;
  reg hsel = 1'h0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'h0;
  reg [31:0] hwdata = 32'h0;
  reg tick = 1'h0;
  reg cpol = 1'h0;
  reg ak;
  reg [7:0] rd, v, tx, rx, sck_per, scl_per, ck, cl;
  reg ps, pl;
  reg [31:0] rnd;
  integer bad_count = 0;
  integer tests_run = 0;
  integer i;
  wire hready, sck_i, sck_o, sck_oe, sdi, sdo, scl_i, scl_oe, sda_i, sda_oe;
  wire [31:0] hrdata;
  wire sdo_oe, own;
  sync_serial_port dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(), .timer_two_tick(tick), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(1'h1),
    .scl_i(scl_i), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(), .sda_oe(sda_oe),
    .port_pins_owned(own));
  serial_far_end far (.core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .sck_o(sck_o),
    .sck_oe(sck_oe), .sdo(sdo), .cpol(cpol), .scl_i(scl_i), .sda_i(sda_i), .sck_i(sck_i),
    .sdi(sdi));
  always #10 core_clk = ~core_clk;
  // Random timer pulses; clock periods measured between rising edges
  always @(posedge core_clk) begin
    // Never two pulses in a row: a half period must outlast the pin lag
    tick <= !tick && (($urandom % 4) == 0);
    ck = ck + 8'h01;
    cl = cl + 8'h01;
    if (sck_o && !ps) sck_per = ck;
    if (sck_o && !ps) ck = 8'h00;
    if (scl_i && !pl) scl_per = cl;
    if (scl_i && !pl) cl = 8'h00;
    ps = sck_o;
    pl = scl_i;
  end
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hready !== 1'h1);
    rd = hrdata[7:0];
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task rck(input string n, input [7:0] a, input [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(n, e, rd);
  endtask
  // Poll until the shifter is no longer busy
  task wait_done;
    integer k;
    rd = 8'h08;
    for (k = 0; k < 400 && rd[3] !== 1'h0; k = k + 1) bus(1'h0, `SPC_A_STAT, 8'h00);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    rnd = $urandom(32'h4344);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    rck("ctl_rst", `SPC_A_CTL, `SPC_CTL_RST);
    rck("hole", 8'h1C, 8'h00);
    // Every legal mode with random clock polarity; reserved codes are never written
    for (i = 0; i < 16; i = i + 1) begin
      rnd = $urandom;
      v = {3'h1, rnd[4], i[3:0]};
      if (i != 9 && i != 10 && i != 12 && i != 13) begin
        bus(1'h1, `SPC_A_CTL, v);
        repeat (6) @(posedge core_clk);
        rck("mode", `SPC_A_CTL, v);
        chk("own", 8'h01, {7'h0, own});
      end
    end
    bus(1'h1, `SPC_A_CTL, 8'h00);
    repeat (4) @(posedge core_clk);
    chk("own_off", 8'h00, {7'h0, own});
    // SPI master at each rate, two transfers with no buffer read between
    for (i = 0; i < 4; i = i + 1) begin
      rnd = $urandom;
      v = {3'h1, rnd[8], i[3:0]};
      bus(1'h1, `SPC_A_CTL, v);
      // Idle level settles before the far side follows the new polarity
      repeat (2) @(posedge core_clk);
      cpol = rnd[8];
      far.stx_r = rnd[23:16];
      bus(1'h1, `SPC_A_BUF, rnd[7:0]);
      wait_done;
      if (i < 3) chk("sck_per", 8'h04 << (2 * i), sck_per);
      chk("slave_rx", rnd[7:0], far.srx_r);
      bus(1'h1, `SPC_A_BUF, rnd[7:0]);
      wait_done;
      rck("no_ovf", `SPC_A_CTL, v);
      rck("mst_rx", `SPC_A_BUF, rnd[23:16]);
    end
    // Bus master: rate from baud register, second write while busy collides
    v = $urandom % 4;
    bus(1'h1, `SPC_A_ABR, v);
    bus(1'h1, `SPC_A_CTL, 8'h28);
    bus(1'h1, `SPC_A_BUF, 8'hC3);
    bus(1'h1, `SPC_A_BUF, 8'h3C);
    wait_done;
    chk("scl_per", 8'h04 * (v + 8'h01), scl_per);
    rck("write_collision_flag", `SPC_A_CTL, 8'hA8);
    bus(1'h1, `SPC_A_CTL, 8'h28);
    rck("write_collision_flag_clr", `SPC_A_CTL, 8'h28);
    rck("i2c_m_rx", `SPC_A_BUF, 8'hC3);
    // SPI slave: unread buffer makes the next byte overflow and vanish
    cpol = 1'h0;
    bus(1'h1, `SPC_A_CTL, 8'h25);
    bus(1'h1, `SPC_A_BUF, 8'h3C);
    far.spi_byte(8'h5A, rx);
    chk("sl_tx", 8'h3C, rx);
    far.spi_byte(8'h96, rx);
    rck("ovf", `SPC_A_CTL, 8'h65);
    rck("kept", `SPC_A_BUF, 8'h5A);
    bus(1'h1, `SPC_A_CTL, 8'h25);
    fork
      far.spi_byte(8'h11, rx);
      begin
        repeat (60) @(posedge core_clk);
        bus(1'h1, `SPC_A_BUF, 8'h77);
      end
    join
    rck("sl_write_collision_flag", `SPC_A_CTL, 8'hA5);
    rck("sl_rx", `SPC_A_BUF, 8'h11);
    // Bus slave: stretch, general call off and on, own address
    bus(1'h1, `SPC_A_ABR, 8'h52);
    bus(1'h1, `SPC_A_CTL, 8'h26);
    repeat (6) @(posedge core_clk);
    chk("stretch", 8'h01, {7'h0, scl_oe});
    bus(1'h1, `SPC_A_CTL, 8'h36);
    far.i2c_start;
    far.i2c_byte(8'h00, ak);
    far.i2c_stop;
    chk("gc_off", 8'h00, {7'h0, ak});
    bus(1'h1, `SPC_A_CTL2, 8'h80);
    bus(1'h1, `SPC_A_STAT, 8'h00);
    far.i2c_start;
    far.i2c_byte(8'h00, ak);
    chk("gc_ack", 8'h01, {7'h0, ak});
    bus(1'h0, `SPC_A_STAT, 8'h00);
    chk("gc_st", 8'h05, rd & 8'h07);
    rck("gc_buf", `SPC_A_BUF, 8'h00);
    rnd = $urandom;
    far.i2c_byte(rnd[7:0], ak);
    rck("data", `SPC_A_BUF, rnd[7:0]);
    far.i2c_byte(8'h0F, ak);
    far.i2c_byte(8'hF0, ak);
    far.i2c_stop;
    chk("i2c_nack", 8'h00, {7'h0, ak});
    rck("i2c_ovf", `SPC_A_CTL, 8'h76);
    rck("i2c_kept", `SPC_A_BUF, 8'h0F);
    bus(1'h1, `SPC_A_CTL, 8'h36);
    far.i2c_start;
    far.i2c_byte(8'h52, ak);
    far.i2c_stop;
    chk("own_ack", 8'h01, {7'h0, ak});
    rck("own_buf", `SPC_A_BUF, 8'h52);
    // Ten-bit: general call skips the second half, own first half asks for it
    bus(1'h1, `SPC_A_ABR, 8'hF0);
    bus(1'h1, `SPC_A_CTL, 8'h37);
    far.i2c_start;
    far.i2c_byte(8'h00, ak);
    bus(1'h0, `SPC_A_STAT, 8'h00);
    chk("gc10_ua", 8'h00, rd & 8'h02);
    rck("gc10_buf", `SPC_A_BUF, 8'h00);
    far.i2c_byte(8'hA5, ak);
    far.i2c_stop;
    chk("gc10_dat", 8'h01, {7'h0, ak});
    rck("gc10_rx", `SPC_A_BUF, 8'hA5);
    far.i2c_start;
    far.i2c_byte(8'hF0, ak);
    bus(1'h0, `SPC_A_STAT, 8'h00);
    chk("ua_set", 8'h02, rd & 8'h02);
    far.i2c_stop;
    give_verdict;
  end
endmodule
